// >>> hdl/dual_reload_timer_control.sv
// two 8-bit down-counting reload timers with tone output and irq flags
// assumes source clocks and event input arrive asynchronously on pins
`timescale 1ns/1ps

// Behaviour
// [RULE1] preset write copies reload value into counter
// [RULE2] preset while running resumes; stopped holds value
// [RULE3] preset bits read zero; zero write ignored
// [RULE4] run bit one counts, zero stops
// [RULE5] stopped counter keeps value until preset
// [RULE6] channel select picks timer driving tone
// [RULE7] tone enable off holds pin high
// [RULE8] software keeps port bit one, highz zero
// [RULE9] per-timer mask bit enables interrupt request
// [RULE10] underflow sets flag regardless of mask
// [RULE11] writing one clears flag; zero ignored
// [RULE12] handler clears flag before re-enabling interrupts
// [RULE13] read low nibble, high within 0.73ms
// [RULE14] run/stop takes effect at next input tick
// [RULE15] run bit reads one until really stopped
// [RULE16] event mode also defers run and stop
// [RULE17] tone gated asynchronously, may glitch half cycle
// [RULE18] software waits 5ms for fast oscillator
// [RULE19] reset clears run, select, enable, masks, flags
// [RULE20] counter reloads automatically on underflow
// [RULE21] low nibble read latches high nibble
// [RULE22] prescaler divides by 1, 4, 32, 256
// [RULE23] tone toggles on each selected underflow
// [RULE24] request raised while flag and mask set
module dual_reload_timer_control
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // register port
   input  wire logic [15:0] addr,
   input  wire logic [3:0]  wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [3:0]  rd_data,
   // timer sources from pins
   input  wire logic        low_speed_clk,
   input  wire logic        high_speed_oscillator,
   input  wire logic        event_in,
   // outputs
   output logic             shared_output_port_bit,
   output logic             tone_output_signal,
   output logic      [1:0]  timer_irq
);

   // =========================================================
   // pin synchronisers
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [2:0] pin_prev;

   // two flops per pin, third stage only for edge detection
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         pin_prev <= 3'h0;
      end
      else
      begin
         pin_meta <= {event_in, high_speed_oscillator, low_speed_clk};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   logic [2:0] pin_fall;
   logic [2:0] pin_rise;
   assign pin_fall = pin_prev & ~pin_sync;
   assign pin_rise = ~pin_prev & pin_sync;

   // =========================================================
   // software registers
   logic [1:0] src_sel;
   logic       tone_enable;
   logic       tone_channel_select;
   logic       event_mode;
   logic       event_rising;
   logic [1:0] irq_mask;
   logic [1:0] irq_flag;
   logic [7:0] reload_value [2];
   logic [3:0] high_latch;
   logic [3:0] next_rd_data;
   logic [1:0] next_src_sel;
   logic       next_tone_enable;
   logic       next_tone_channel_select;
   logic       next_event_mode;
   logic       next_event_rising;
   logic [1:0] next_irq_mask;
   logic [1:0] next_irq_flag;
   logic [7:0] next_reload_value [2];
   logic [3:0] next_high_latch;

   // strobes toward the timers
   logic [1:0] preset_pulse;
   logic [1:0] run_write;
   logic [1:0] underflow;
   logic [7:0] count [2];
   reload_timer_pkg::timer_ctrl_s ctrl [2];

   // register decode, write effects and read mux
   always_comb
   begin
      next_src_sel             = src_sel;
      next_tone_enable         = tone_enable;
      next_tone_channel_select = tone_channel_select;
      next_event_mode          = event_mode;
      next_event_rising        = event_rising;
      next_irq_mask            = irq_mask;
      next_irq_flag            = irq_flag | underflow;              // [RULE10]
      next_reload_value        = reload_value;
      next_high_latch          = high_latch;
      next_rd_data             = 4'h0;
      preset_pulse             = 2'h0;
      run_write                = 2'h0;
      if (wr_en)
      begin
         case (addr)
            reload_timer_pkg::OFS_COUNT_MODE:
            begin
               next_event_mode   = wr_data[reload_timer_pkg::EVENT_MODE_BIT];
               next_event_rising = wr_data[reload_timer_pkg::EVENT_POL_BIT];
            end
            reload_timer_pkg::OFS_TONE_CTRL:
            begin
               next_src_sel             = wr_data[1:0];
               next_tone_enable         = wr_data[reload_timer_pkg::TONE_EN_BIT];
               next_tone_channel_select = wr_data[reload_timer_pkg::CHAN_SEL_BIT];
            end
            reload_timer_pkg::OFS_T0_CTRL:
            begin
               preset_pulse[0] = wr_data[reload_timer_pkg::PRESET_BIT];     // [RULE3]
               run_write[0]    = 1'b1;
            end
            reload_timer_pkg::OFS_T1_CTRL:
            begin
               preset_pulse[1] = wr_data[reload_timer_pkg::PRESET_BIT];     // [RULE3]
               run_write[1]    = 1'b1;
            end
            reload_timer_pkg::OFS_RELOAD_BASE:
               next_reload_value[0][3:0] = wr_data;
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0001:
               next_reload_value[0][7:4] = wr_data;
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0002:
               next_reload_value[1][3:0] = wr_data;
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0003:
               next_reload_value[1][7:4] = wr_data;
            reload_timer_pkg::OFS_IRQ_MASK:
               next_irq_mask = wr_data[1:0];                               // [RULE9]
            reload_timer_pkg::OFS_IRQ_FLAGS:
               next_irq_flag = (irq_flag & ~wr_data[1:0]) | underflow;     // [RULE11]
            default:
               next_irq_mask = irq_mask;
         endcase
      end
      if (rd_en)
      begin
         case (addr)
            reload_timer_pkg::OFS_COUNT_MODE:
               next_rd_data = {1'b0, event_mode, 1'b0, event_rising};
            reload_timer_pkg::OFS_TONE_CTRL:
               next_rd_data = {tone_channel_select, tone_enable, src_sel};
            reload_timer_pkg::OFS_T0_CTRL:                                 // [RULE15]
               next_rd_data = {ctrl[0].prescale, 1'b0,
                               ctrl[0].run_request | ctrl[0].running};
            reload_timer_pkg::OFS_T1_CTRL:
               next_rd_data = {ctrl[1].prescale, 1'b0,
                               ctrl[1].run_request | ctrl[1].running};
            reload_timer_pkg::OFS_RELOAD_BASE:
               next_rd_data = reload_value[0][3:0];
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0001:
               next_rd_data = reload_value[0][7:4];
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0002:
               next_rd_data = reload_value[1][3:0];
            reload_timer_pkg::OFS_RELOAD_BASE + 16'h0003:
               next_rd_data = reload_value[1][7:4];
            reload_timer_pkg::OFS_COUNT_BASE:
            begin
               next_rd_data    = count[0][3:0];
               next_high_latch = count[0][7:4];                            // [RULE21]
            end
            reload_timer_pkg::OFS_COUNT_BASE + 16'h0002:
            begin
               next_rd_data    = count[1][3:0];
               next_high_latch = count[1][7:4];                            // [RULE21]
            end
            reload_timer_pkg::OFS_COUNT_BASE + 16'h0001,
            reload_timer_pkg::OFS_COUNT_BASE + 16'h0003:
               next_rd_data = high_latch;
            reload_timer_pkg::OFS_IRQ_MASK:
               next_rd_data = {2'h0, irq_mask};
            reload_timer_pkg::OFS_IRQ_FLAGS:
               next_rd_data = {2'h0, irq_flag};
            default:
               next_rd_data = 4'h0;
         endcase
      end
   end

   // register state
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_sel             <= 2'h0;
         tone_enable         <= 1'b0;                                      // [RULE19]
         tone_channel_select <= 1'b0;
         event_mode          <= 1'b0;
         event_rising        <= 1'b0;
         irq_mask            <= 2'h0;
         irq_flag            <= 2'h0;
         reload_value[0]     <= reload_timer_pkg::RELOAD_RESET;
         reload_value[1]     <= reload_timer_pkg::RELOAD_RESET;
         high_latch          <= 4'h0;
         rd_data             <= 4'h0;
      end
      else
      begin
         src_sel             <= next_src_sel;
         tone_enable         <= next_tone_enable;
         tone_channel_select <= next_tone_channel_select;
         event_mode          <= next_event_mode;
         event_rising        <= next_event_rising;
         irq_mask            <= next_irq_mask;
         irq_flag            <= next_irq_flag;
         reload_value        <= next_reload_value;
         high_latch          <= next_high_latch;
         rd_data             <= next_rd_data;
      end
   end

   // =========================================================
   // per-timer prescaler, run control and counter
   for (genvar t = 0; t < 2; t++)
   begin : g_timer
      logic                          src_edge;
      logic                          tick;
      logic [7:0]                    psc;
      logic [7:0]                    next_psc;
      logic [7:0]                    next_count;
      reload_timer_pkg::timer_ctrl_s next_ctrl;
      logic                          next_underflow;

      // source edge: event pin for timer 0 in event mode, else selected clock
      always_comb
      begin
         src_edge = src_sel[t] ? pin_fall[1] : pin_fall[0];
         if (t == 0 && event_mode)
            src_edge = event_rising ? pin_rise[2] : pin_fall[2];
      end

      // prescaler; bypassed for timer 0 in event mode
      always_comb
      begin
         next_psc = psc;
         tick     = 1'b0;
         if (t == 0 && event_mode)
         begin
            tick     = src_edge;
            next_psc = reload_timer_pkg::PSC_RESET;
         end
         else if (src_edge)
         begin
            if (psc >= reload_timer_pkg::prescale_limit(ctrl[t].prescale)) // [RULE22]
            begin
               tick     = 1'b1;
               next_psc = reload_timer_pkg::PSC_RESET;
            end
            else
               next_psc = psc + 8'h01;
         end
      end

      // run request, deferred run state and count
      always_comb
      begin
         next_ctrl      = ctrl[t];
         next_count     = count[t];
         next_underflow = 1'b0;
         if (run_write[t])
         begin
            next_ctrl.run_request = wr_data[reload_timer_pkg::RUN_BIT];    // [RULE4]
            next_ctrl.prescale    = wr_data[reload_timer_pkg::PSC_LSB +: 2];
         end
         if (tick)
         begin
            next_ctrl.running = next_ctrl.run_request;                     // [RULE14] [RULE16]
            if (ctrl[t].running)                                           // [RULE5]
            begin
               if (count[t] == 8'h00)
               begin
                  next_count     = reload_value[t];                        // [RULE20]
                  next_underflow = 1'b1;
               end
               else
                  next_count = count[t] - 8'h01;
            end
         end
         if (preset_pulse[t])
            next_count = reload_value[t];                                  // [RULE1] [RULE2]
      end

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
         if (!rst_n)
         begin
            psc          <= reload_timer_pkg::PSC_RESET;
            ctrl[t]      <= '0;                                            // [RULE19]
            count[t]     <= reload_timer_pkg::COUNT_RESET;
            underflow[t] <= 1'b0;
         end
         else
         begin
            psc          <= next_psc;
            ctrl[t]      <= next_ctrl;
            count[t]     <= next_count;
            underflow[t] <= next_underflow;
         end
      end
   end

   // =========================================================
   // tone generator
   logic next_tone;

   // toggle on each underflow of the chosen timer
   always_comb
   begin
      next_tone = tone_output_signal;
      if (underflow[tone_channel_select])                                   // [RULE6]
         next_tone = ~tone_output_signal;                                   // [RULE23]
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tone_output_signal <= 1'b0;
      else
         tone_output_signal <= next_tone;
   end

   // gating is not aligned to the tone, so switching may clip a half cycle
   assign shared_output_port_bit = ~tone_enable | tone_output_signal;       // [RULE7] [RULE17]

   // interrupt request per timer
   assign timer_irq = irq_flag & irq_mask;                                  // [RULE24]

endmodule

// >>> hdl/reload_timer_pkg.sv
// constants, field layout and control carrier of the dual reload timer
// assumes a 16-bit register address and 4-bit register data
package reload_timer_pkg;

   // ==========================================================
   // bus and counter widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 4;
   localparam int CNT_W  = 8;

   // ==========================================================
   // register addresses
   localparam logic [15:0] OFS_COUNT_MODE  = 16'hffc0;
   localparam logic [15:0] OFS_TONE_CTRL   = 16'hffc1;
   localparam logic [15:0] OFS_T0_CTRL     = 16'hffc2;
   localparam logic [15:0] OFS_T1_CTRL     = 16'hffc3;
   localparam logic [15:0] OFS_RELOAD_BASE = 16'hffc4;
   localparam logic [15:0] OFS_COUNT_BASE  = 16'hffc8;
   localparam logic [15:0] OFS_IRQ_MASK    = 16'hffe2;
   localparam logic [15:0] OFS_IRQ_FLAGS   = 16'hfff2;

   // ==========================================================
   // field positions
   localparam int RUN_BIT        = 0;
   localparam int PRESET_BIT     = 1;
   localparam int PSC_LSB        = 2;
   localparam int SRC_SEL0_BIT   = 0;
   localparam int SRC_SEL1_BIT   = 1;
   localparam int TONE_EN_BIT    = 2;
   localparam int CHAN_SEL_BIT   = 3;
   localparam int EVENT_POL_BIT  = 0;
   localparam int EVENT_MODE_BIT = 2;

   // ==========================================================
   // values after reset
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET  = 8'h00;
   localparam logic [7:0] PSC_RESET    = 8'h00;

   // ==========================================================
   // prescaler terminal counts for divide by 1, 4, 32, 256
   localparam logic [7:0] PSC_LIM_DIV1   = 8'h00;
   localparam logic [7:0] PSC_LIM_DIV4   = 8'h03;
   localparam logic [7:0] PSC_LIM_DIV32  = 8'h1f;
   localparam logic [7:0] PSC_LIM_DIV256 = 8'hff;

   // per-timer control state
   typedef struct packed {
      logic       run_request;
      logic       running;
      logic [1:0] prescale;
   } timer_ctrl_s;

   // terminal count of the prescaler for a division code
   function automatic logic [7:0] prescale_limit(input logic [1:0] code);
      case (code)
         2'h1:    prescale_limit = PSC_LIM_DIV4;
         2'h2:    prescale_limit = PSC_LIM_DIV32;
         2'h3:    prescale_limit = PSC_LIM_DIV256;
         default: prescale_limit = PSC_LIM_DIV1;
      endcase
   endfunction

endpackage

// >>> verification/testbench.sv
// self-checking bench for the dual reload timer control
// assumes design and checker compiled first; drives low_speed_clk, hso and evi ticks
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
   // ==============================
   // signals and model state
   logic        clk_sys;
   logic        rst_n;
   logic [15:0] addr;
   logic [3:0]  wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [3:0]  rd_data;
   logic        low_speed_clk;
   logic        hso;
   logic        evi;
   logic        shared;
   logic        tone;
   logic [1:0]  irq;
   logic [7:0]  cnt [2];
   logic [7:0]  rld [2];
   logic        rq [2];
   logic        rn [2];
   logic [1:0]  flg;
   logic [1:0]  msk;
   logic        ten;
   logic        chs;
   logic        tn;
   logic [1:0]  ps [2];
   int          psc [2];
   logic [1:0]  src;
   logic        evm;
   logic        evr;
   logic [31:0] r;
   int          seed;
   int          miscompares;
   int          tests_run;
   int          cycles;

   dual_reload_timer_control i_dual_reload_timer_control
   (
      .clk_sys               (clk_sys),
      .rst_n                 (rst_n),
      .addr                  (addr),
      .wr_data               (wr_data),
      .wr_en                 (wr_en),
      .rd_en                 (rd_en),
      .rd_data               (rd_data),
      .low_speed_clk         (low_speed_clk),
      .high_speed_oscillator (hso),
      .event_in              (evi),
      .shared_output_port_bit(shared),
      .tone_output_signal    (tone),
      .timer_irq             (irq)
   );

   // clock
   always #2.5 clk_sys = ~clk_sys;

   // ==============================
   // bus and model tasks
   task automatic wr(input logic [15:0] a, input logic [3:0] v);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= v;
      wr_en   <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [3:0] e);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      `CHK(rd_data, e)
   endtask

   task automatic ctl(input logic i, input logic p, input logic v, input logic [1:0] s);
      wr({15'h7fe1, i}, {s, p, v});
      rq[i] = v;
      ps[i] = s;
      if (p)
         cnt[i] = rld[i];
      rd({15'h7fe1, i}, {s, 1'b0, rq[i] | rn[i]});
   endtask

   // last prescaler count for divide by 1, 4, 32, 256
   function automatic int lim(input logic [1:0] c);
      lim = (c == 2'h0) ? 0 : (c == 2'h1) ? 3 : (c == 2'h2) ? 31 : 255;
   endfunction

   // one pulse on the chosen pins {event, fast, slow}, then the model steps
   task automatic tick(input logic [2:0] p);
      logic e;
      @(posedge clk_sys);
      {evi, hso, low_speed_clk} <= p; // fast source taken as settled
      repeat (4) @(posedge clk_sys);
      {evi, hso, low_speed_clk} <= 3'h0;
      repeat (10) @(posedge clk_sys);
      for (int i = 0; i < 2; i++)
      begin
         e = 1'b0;
         if (i == 0 && evm)
            e = p[2];
         else if (p[src[i]])
         begin
            e = psc[i] >= lim(ps[i]);
            psc[i] = e ? 0 : psc[i] + 1;
         end
         if (e)
         begin
            if (rn[i] && cnt[i] == 8'h00)
            begin
               cnt[i] = rld[i];
               flg[i] = 1'b1;
               if (chs == i[0])
                  tn = ~tn;
            end
            else if (rn[i])
               cnt[i] = cnt[i] - 8'h01;
            rn[i] = rq[i];
         end
      end
   endtask

   task automatic chk;
      for (int i = 0; i < 2; i++)
      begin
         rd({14'h3ff2, i[0], 1'b0}, cnt[i][3:0]);
         rd({14'h3ff2, i[0], 1'b1}, cnt[i][7:4]);
      end
      rd(16'hfff2, {2'b00, flg});
      rd(16'hffe2, {2'b00, msk});
      rd(16'hffc1, {chs, ten, src});
      rd(16'hffc0, {1'b0, evm, 1'b0, evr});
      `CHK(irq, flg & msk)
      `CHK(tone, tn)
      `CHK(shared, ten ? tn : 1'b1)
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         miscompares++;
         finish_test;
      end
   end

   // ==============================
   // main sequence
   initial
   begin
      seed = 32'h1e75a25f;
      {clk_sys, rst_n, wr_en, rd_en, low_speed_clk, hso, evi, addr, wr_data} = '0;
      {miscompares, tests_run, cycles} = '0;
      {flg, msk, ten, chs, tn, src, evm, evr} = '0;
      psc = '{0, 0};
      ps  = '{2'h0, 2'h0};
      cnt = '{8'h00, 8'h00};
      rq  = '{1'b0, 1'b0};
      rn  = '{1'b0, 1'b0};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk;
      rd(16'hffd0, 4'h0);
      for (int i = 0; i < 2; i++)
      begin
         r = $random(seed);
         rld[i] = i ? r[7:0] : {5'h00, r[2:0]};
         wr({14'h3ff1, i[0], 1'b0}, rld[i][3:0]);
         wr({14'h3ff1, i[0], 1'b1}, rld[i][7:4]);
         ctl(i[0], 1'b1, 1'b0, 2'h0);
      end
      tick(3'h1);
      chk;
      wr(16'hffc1, 4'h4); // port bit held one, not high-z
      ten = 1'b1;
      ctl(1'b0, 1'b0, 1'b1, 2'h0);
      ctl(1'b1, 1'b0, 1'b1, 2'h1);
      for (int k = 0; k < 12; k++)
      begin
         tick(3'h1);
         chk;
      end
      wr(16'hffe2, 4'h1);
      msk = 2'h1;
      wr(16'hfff2, 4'h0);
      chk;
      wr(16'hfff2, 4'h1);
      flg[0] = 1'b0;
      ctl(1'b0, 1'b0, 1'b0, 2'h0);
      for (int k = 0; k < 2; k++)
      begin
         tick(3'h1);
         chk;
      end
      ctl(1'b1, 1'b1, 1'b1, 2'h1);
      for (int k = 0; k < 60; k++)
      begin
         r = $random(seed);
         case (r[2:0])
            3'h3: ctl(r[3], r[4], r[5], r[7:6]);
            3'h4:
            begin
               wr(16'hffc1, {r[3], r[4], r[6:5]});
               chs = r[3];
               ten = r[4];
               src = r[6:5];
            end
            3'h7:
            begin
               wr(16'hffc0, {1'b0, r[3], 1'b0, r[4]});
               evm = r[3];
               evr = r[4];
               if (r[3])
                  psc[0] = 0;
            end
            3'h5:
            begin
               wr(16'hffe2, {2'b00, r[4:3]});
               msk = r[4:3];
            end
            3'h6:
            begin
               wr(16'hfff2, {2'b00, r[4:3]});
               flg = flg & ~r[4:3];
            end
            default: tick(r[5:3]);
         endcase
         chk;
      end
      finish_test;
   end
endmodule

bind dual_reload_timer_control timer_ctrl_assertions i_timer_ctrl_assertions
(
   .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .low_speed_clk(low_speed_clk),
   .high_speed_oscillator(high_speed_oscillator), .event_in(event_in),
   .shared_output_port_bit(shared_output_port_bit),
   .tone_output_signal(tone_output_signal), .timer_irq(timer_irq)
);

// >>> verification/timer_ctrl_assertions.sv
// checker for the dual reload timer control, port level only
// assumes a bind to the design top; single clock domain
`timescale 1ns/1ps
module timer_ctrl_assertions
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // register port
   input wire logic [15:0] addr,
   input wire logic [3:0]  wr_data,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [3:0]  rd_data,
   // source pins
   input wire logic        low_speed_clk,
   input wire logic        high_speed_oscillator,
   input wire logic        event_in,
   // outputs
   input wire logic        shared_output_port_bit,
   input wire logic        tone_output_signal,
   input wire logic [1:0]  timer_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ==============================
   // shadow state
   logic [2:0] pins;
   logic [2:0] next_pins;
   logic [3:0] qcnt;
   logic [3:0] next_qcnt;
   logic       ten;
   logic       next_ten;
   logic [1:0] mask;
   logic [1:0] next_mask;
   logic       quiet;

   // next values from writes and source pin changes
   always_comb
   begin
      next_pins = {low_speed_clk, high_speed_oscillator, event_in};
      next_qcnt = (next_pins != pins) ? 4'h0 : qcnt + {3'h0, qcnt != 4'hf};
      next_ten  = (wr_en && addr == 16'hffc1) ? wr_data[2] : ten;
      next_mask = (wr_en && addr == 16'hffe2) ? wr_data[1:0] : mask;
   end

   // register the shadows
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins <= 3'h0;
         qcnt <= 4'h0;
         ten  <= 1'b0;
         mask <= 2'h0;
      end
      else
      begin
         pins <= next_pins;
         qcnt <= next_qcnt;
         ten  <= next_ten;
         mask <= next_mask;
      end
   end

   // no tick can be in flight once the pins sat still this long
   assign quiet = qcnt[3];

   // ==============================
   // sequences
   sequence rd_ctrl;
      rd_en && (addr == 16'hffc2 || addr == 16'hffc3);
   endsequence
   sequence wr_run;
      wr_en && addr == 16'hffc2 && wr_data[0];
   endsequence

   // ==============================
   // properties
   pin_gate_a:
      assert property (shared_output_port_bit == (ten ? tone_output_signal : 1'b1))
      else $error("tone pin level wrong");
   irq_gate_a:
      assert property ((timer_irq & ~mask) == 2'b00)
      else $error("request without mask");
   irq_hold_a:
      assert property (quiet && !wr_en |=> $stable(timer_irq))
      else $error("request moved without cause");
   tone_hold_a:
      assert property (quiet |=> $stable(tone_output_signal))
      else $error("tone moved without underflow");
   preset_read_a:
      assert property (rd_ctrl |=> !rd_data[1])
      else $error("preset bit read nonzero");
   run_read_a:
      assert property (wr_run ##1 !wr_en ##1 (rd_en && addr == 16'hffc2) |=> rd_data[0])
      else $error("run bit not read back");
   flag_clear_a:
      assert property (quiet && wr_en && addr == 16'hfff2 && wr_data[0] |=> !timer_irq[0])
      else $error("flag not cleared");
   zero_write_a:
      assert property (quiet && wr_en && addr == 16'hfff2 && wr_data[1:0] == 2'b00
                       |=> $stable(timer_irq))
      else $error("zero write changed flags");
endmodule
